// File: design/porc_power_on_reset_counter.sv
// Power-on reset counter with internal reset generation
//
// Behaviour
// [RULE1] Hold internal reset 4064 oscillator cycles, or 4096 on other variant.
// [RULE2] Withdraw hold request when the startup hold count completes.
// [RULE3] Core leaves reset only when hold withdrawn and no source active.
// [RULE4] Init pulse ends on completion feedback from every preset circuit.
// [RULE5] Init pulse presets reset logic asserted and counter to start count.
// [RULE6] Reset length comes from the counter, not the init pulse.
// [RULE7] Counter runs on the oscillator clock, so duration scales with it.
// [RULE8] Internal reset asserted while any reset source is active.
// [RULE9] Init path does not retrigger on a supply dip.
// [RULE10] Internal reset and init pulse are active high.
// [RULE11] Low supply reset clears and stalls the hold counter.
// [RULE12] Drive the active-low reset pin low during internal reset; not driven for ext_reset or a low pin.
// [RULE13] Core reset release is synchronous to the oscillator clock.
`timescale 1ns/1ns
`include "porc_defs.svh"
module porc_power_on_reset_counter #(
  parameter bit VARIANT_B = 1'b0
) (
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire porc_pkg::porc_sources_t sources_in,
  input  wire logic                   reset_pin_in,
  output logic                        init_pulse,
  output logic                        hold_request,
  output logic                        internal_reset,
  output logic                        core_reset,
  output logic                        reset_pin_out,
  output logic                        reset_pin_oe
);
  import porc_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  porc_sources_t src_meta_reg;
  porc_sources_t src_sync_reg;
  logic          pin_meta_reg;
  logic          pin_sync_reg;

  always_ff @(posedge clock) begin
    src_meta_reg <= sources_in;
    src_sync_reg <= src_meta_reg;
    pin_meta_reg <= reset_pin_in;
    pin_sync_reg <= pin_meta_reg;
  end

  // ----------------------------------------------------------------
  // Sequencer state and hold counter
  // ----------------------------------------------------------------
  localparam porc_count_t HOLD_LEN = VARIANT_B ? `PORC_HOLD_CYCLES_B // RULE1
                                               : `PORC_HOLD_CYCLES_A;

  porc_state_t state_reg;
  porc_state_t state_next;
  porc_count_t count_reg;
  porc_count_t count_next;
  logic        armed_reg;
  logic        gen_done_reg;
  logic        cnt_done_reg;

  wire logic low_supply   = src_sync_reg.low_supply_reset;
  // Pin is low while our own drive or an outside party pulls it
  wire logic ext_active   = src_sync_reg.ext_reset | ~pin_sync_reg;
  wire logic other_active = low_supply | ext_active
                          | src_sync_reg.other_reset;
  wire logic count_end    = (count_reg == HOLD_LEN - `PORC_CNT_ONE);
  wire logic feedback_all = gen_done_reg & cnt_done_reg;

  // Init pulse comes only once per arm; reset_n models the supply rise
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      PORC_ST_INIT: begin
        count_next = `PORC_CNT_ZERO;                              // RULE5
        if (feedback_all) begin
          state_next = PORC_ST_HOLD;                              // RULE4
        end
      end
      PORC_ST_HOLD: begin
        if (low_supply) begin
          count_next = `PORC_CNT_ZERO;                            // RULE11
        end else if (count_end) begin
          state_next = PORC_ST_RUN;                               // RULE2
        end else begin
          count_next = count_reg + `PORC_CNT_ONE;                 // RULE7
        end
      end
      PORC_ST_RUN: begin
        // Dips only restart the count, never the init pulse
        if (low_supply) begin
          state_next = PORC_ST_HOLD;                              // RULE9
          count_next = `PORC_CNT_ZERO;                            // RULE11
        end
      end
      default: begin
        state_next = PORC_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg    <= PORC_ST_INIT;
      count_reg    <= `PORC_CNT_ZERO;
      armed_reg    <= 1'b0;
      gen_done_reg <= 1'b0;
      cnt_done_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      armed_reg    <= 1'b1;
      gen_done_reg <= armed_reg;                                  // RULE4
      cnt_done_reg <= armed_reg;                                  // RULE4
    end
  end

  // ----------------------------------------------------------------
  // Reset generation outputs
  // ----------------------------------------------------------------
  wire logic init_next  = (state_next == PORC_ST_INIT);           // RULE10
  wire logic hold_next  = (state_next != PORC_ST_RUN);            // RULE6
  wire logic reset_next = hold_next | other_active;               // RULE8
  wire logic core_next  = ~(~hold_next & ~other_active);          // RULE3

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      init_pulse     <= 1'b1;
      hold_request   <= 1'b1;
      internal_reset <= 1'b1;
      core_reset     <= 1'b1;
      reset_pin_out  <= 1'b0;
      reset_pin_oe   <= 1'b1;
    end else begin
      init_pulse     <= init_next;
      hold_request   <= hold_next;
      internal_reset <= reset_next;                               // RULE8
      core_reset     <= core_next;                                // RULE13
      reset_pin_out  <= 1'b0;
      // Drive only for our own hold, low supply or other reset, else pin latches up
      reset_pin_oe   <= hold_next | low_supply
                      | src_sync_reg.other_reset;                 // RULE12
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Stands from the arm until both done flags are back
  logic [3:0]  init_cnt_reg;
  always_ff @(posedge clock) begin
    if (!reset_n || !init_pulse) begin
      init_cnt_reg <= 4'h0;
    end else if (init_cnt_reg != 4'hF) begin
      init_cnt_reg <= init_cnt_reg + 4'h1;
    end
  end

  int unsigned hold_cnt_reg;
  always_ff @(posedge clock) begin
    if (!reset_n || state_reg != PORC_ST_HOLD || low_supply) begin
      hold_cnt_reg <= 0;
    end else begin
      hold_cnt_reg <= hold_cnt_reg + 1;
    end
  end

  a_hold_length: assert property ( // RULE1
    @(posedge clock) disable iff (!reset_n)
    (state_reg == PORC_ST_HOLD && state_next == PORC_ST_RUN)
      |-> hold_cnt_reg == HOLD_LEN - 1)
    else $error("Hold period length wrong");
  a_count_range: assert property ( // RULE1
    @(posedge clock) disable iff (!reset_n)
    count_reg < HOLD_LEN)
    else $error("Hold counter out of range");
  a_hold_withdraw: assert property ( // RULE2
    @(posedge clock) disable iff (!reset_n)
    (state_reg == PORC_ST_HOLD && count_end && !low_supply)
      |=> !hold_request)
    else $error("Hold request not withdrawn");
  a_core_release: assert property ( // RULE3
    @(posedge clock) disable iff (!reset_n)
    !core_reset |-> $past(!hold_next && !other_active))
    else $error("Core released too early");
  a_reset_release: assert property ( // RULE3
    @(posedge clock) disable iff (!reset_n)
    (!hold_next && !other_active) |=> !internal_reset)
    else $error("Internal reset not released");
  a_init_short: assert property ( // RULE4
    @(posedge clock) disable iff (!reset_n)
    $rose(gen_done_reg) |-> ##[1:2] !init_pulse)
    else $error("Init pulse not removed");
  a_init_brief: assert property ( // RULE4
    @(posedge clock) disable iff (!reset_n)
    init_cnt_reg <= `PORC_INIT_MAX_CYCLES)
    else $error("Init pulse lasted too long");
  a_init_preset: assert property ( // RULE5
    @(posedge clock) disable iff (!reset_n)
    init_pulse |-> internal_reset && count_reg == `PORC_CNT_ZERO)
    else $error("Init pulse did not preset");
  a_hold_start: assert property ( // RULE5
    @(posedge clock) disable iff (!reset_n)
    $fell(init_pulse) |-> hold_request && count_reg == `PORC_CNT_ZERO)
    else $error("Hold did not start from zero");
  a_no_retrigger: assert property ( // RULE9
    @(posedge clock) disable iff (!reset_n)
    $fell(init_pulse) |=> !init_pulse [*8])
    else $error("Init pulse retriggered");
  a_low_clear: assert property ( // RULE11
    @(posedge clock) disable iff (!reset_n)
    (low_supply && state_reg != PORC_ST_INIT) |=> count_reg == `PORC_CNT_ZERO)
    else $error("Counter not cleared on low supply");
  a_low_hold: assert property ( // RULE11
    @(posedge clock) disable iff (!reset_n)
    low_supply |=> hold_request)
    else $error("Hold not requested on low supply");
  a_pin_drive: assert property ( // RULE12
    @(posedge clock) disable iff (!reset_n)
    hold_request |-> reset_pin_oe && !reset_pin_out)
    else $error("Reset pin not driven low");
  a_source_or: assert property ( // RULE8
    @(posedge clock) disable iff (!reset_n)
    $past(other_active) |-> internal_reset)
    else $error("Reset source ignored");
endmodule

// File: design/porc_defs.svh
// Constants for the power-on reset counter
`ifndef PORC_DEFS_SVH
`define PORC_DEFS_SVH
`define PORC_HOLD_CYCLES_A 13'h0_FE0
`define PORC_HOLD_CYCLES_B 13'h1_000
`define PORC_CNT_W         13
`define PORC_CNT_ZERO      13'h0_000
`define PORC_CNT_ONE       13'h0_001
`define PORC_INIT_MAX_CYCLES 4'h3
`endif

// File: design/porc_pkg.sv
// Types for the power-on reset counter
`include "porc_defs.svh"
package porc_pkg;
  typedef logic [`PORC_CNT_W-1:0] porc_count_t;
  typedef enum logic [1:0] {
    PORC_ST_INIT = 2'b00,
    PORC_ST_HOLD = 2'b01,
    PORC_ST_RUN  = 2'b10
  } porc_state_t;
  typedef struct packed {
    logic low_supply_reset;
    logic ext_reset;
    logic other_reset;
  } porc_sources_t;
endpackage

// File: dv/porc_far_side.sv
// Far-side model: external reset pin wiring with its pull-up
`timescale 1ns/1ns
module porc_far_side (
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe,
  input  wire logic ext_low,
  output logic      pin_level
);
  // Pull-up lifts the pin once nobody pulls it low
  assign pin_level = ~(ext_low | (reset_pin_oe & ~reset_pin_out));
endmodule

// File: dv/tb_power_on_reset_counter.sv
// Testbench for the power-on reset counter
`timescale 1ns/1ns
module tb_power_on_reset_counter;
  import porc_pkg::*;
  logic          clock;
  logic          reset_n;
  porc_sources_t src;
  logic          ext_low;
  logic          pin;
  logic          ip, hr, ir, cr, po, poe, cr_b;
  int            n_errors = 0;
  int            checks = 0;
  // --------------------------------------------------------------
  // Clock, design and far side
  // --------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  porc_power_on_reset_counter u_dut (
    .clock(clock), .reset_n(reset_n), .sources_in(src),
    .reset_pin_in(pin), .init_pulse(ip), .hold_request(hr),
    .internal_reset(ir), .core_reset(cr), .reset_pin_out(po),
    .reset_pin_oe(poe));
  // Second variant shares all sources; its pin is left released
  porc_power_on_reset_counter #(.VARIANT_B(1'b1)) u_dut_b (
    .clock(clock), .reset_n(reset_n), .sources_in(src),
    .reset_pin_in(1'b1), .init_pulse(), .hold_request(),
    .internal_reset(), .core_reset(cr_b), .reset_pin_out(),
    .reset_pin_oe());
  porc_far_side u_far (.reset_pin_out(po), .reset_pin_oe(poe),
    .ext_low(ext_low), .pin_level(pin));
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Cycles each variant holds its core in reset, counted from now
  task automatic hold_cycles(output int a, output int b);
    a = 0;
    b = 0;
    for (int i = 0; i < 5000 && (cr !== 1'b0 || cr_b !== 1'b0); i++) begin
      if (cr === 1'b1) a++;
      if (cr_b === 1'b1) b++;
      step(1);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_power_up();
    int a, b;
    check({ip, hr, ir, cr, poe, po}, 6'h3e);
    reset_n = 1'b1;
    step(3);
    check({ip, cr}, 2'h1);
    hold_cycles(a, b);
    check(16'(a >= 4064 && a <= 4070), 16'h0001);
    check(16'(b >= 4096 && b <= 4102), 16'h0001);
    check({hr, ir, poe, pin}, 4'h1);
  endtask
  task automatic t_sources();
    src = 3'h1;
    step(5);
    check({ir, cr, poe}, 3'h7);
    src = 3'h2;
    step(5);
    check({ir, cr, poe}, 3'h6);
    src = 3'h0;
    ext_low = 1'b1;
    step(5);
    check({ir, cr, pin}, 3'h6);
    ext_low = 1'b0;
    step(5);
    check({ip, ir, cr, pin}, 4'h1);
  endtask
  task automatic t_low_supply();
    int a, b;
    src = 3'h4;
    step(20);
    check({ip, hr, cr, poe}, 4'h7);
    src = 3'h0;
    hold_cycles(a, b);
    check(16'(a >= 4064 && a <= 4072), 16'h0001);
    check(16'(b >= 4096 && b <= 4102), 16'h0001);
    check(ip, 1'b0);
  endtask
  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    src = 3'h0;
    ext_low = 1'b0;
    step(8);
    t_power_up();
    t_sources();
    t_low_supply();
    finish_test();
  end
  initial begin
    #200_000;
    n_errors++;
    finish_test();
  end
endmodule
